// [lpds_lps_gen.sv]
`timescale 1ns/1ns
module lpds_lps_gen
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [7:0] period,
  input wire logic [7:0] high,
  // pulse out
  output logic lps
);
  import lpds_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic lps_r;
  logic lps_nxt;

  // ==========================================================
  // free-running counter, silent while stopped
  always_comb
  begin
    cnt_nxt = 8'h00;
    lps_nxt = 1'b0;
    if (run)
    begin
      cnt_nxt = (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
      // high on the count being left, so the first pulse after start is full width
      lps_nxt = (cnt_r < high);
    end
  end

  // register state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      lps_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      lps_r <= lps_nxt;
    end
  end

  assign lps = lps_r;

endmodule : lpds_lps_gen

// [lpds_phy_model.sv]
`timescale 1ns/1ns
// ==========================================
// phy model: clock runs only while pulses arrive
module lpds_phy_model
#(
  parameter realtime STOP_NS = 2000
)
(
  // pulse in
  input logic lps,
  // link side
  output logic sysclk,
  output logic link_init
);
  realtime last_r = 0;
  // time of the latest pulse
  always @(posedge lps) last_r = $realtime;
  // clock stops low, as with the pull-down, when pulses cease
  initial
  begin
    sysclk = 0;
    link_init = 0;
    forever
    begin
      #160;
      link_init = ($realtime - last_r) < STOP_NS;
      sysclk = link_init & ~sysclk;
    end
  end
endmodule : lpds_phy_model

// [lpds_pkg.sv]
package lpds_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] LPDS_PSR_ADDR = 4'h0;     // power status register
  localparam logic [3:0] LPDS_LPSCFG_ADDR = 4'h1;  // pulse high/period counts
  localparam int LPDS_SOFT_DOWN_BIT = 0;
  localparam int LPDS_CLK_ACT_BIT = 1;
  localparam int LPDS_CLK_INACT_BIT = 2;
  localparam int LPDS_LINK_INIT_BIT = 3;
  localparam int LPDS_PDPIN_BIT = 4;
  localparam int LPDS_LEGACY_BIT = 5;
  localparam int LPDS_REQ_BIT = 6;
  // pulse configuration word fields
  localparam int LPDS_HIGH_LSB = 0;
  localparam int LPDS_HIGH_MSB = 7;
  localparam int LPDS_PER_LSB = 8;
  localparam int LPDS_PER_MSB = 15;

  // ==========================================================
  // timing
  localparam int LPDS_CLK_MHZ = 25;
  localparam int LPDS_LPS_KHZ = 2000;       // pulse rate, inside 1.0 .. 2.75 MHz
  localparam int LPDS_DUTY_PCT = 25;        // duty, inside 23 .. 28 percent
  localparam logic [7:0] LPDS_LPS_PERIOD =
    8'((LPDS_CLK_MHZ * 1000 + LPDS_LPS_KHZ - 1) / LPDS_LPS_KHZ);
  localparam logic [7:0] LPDS_LPS_HIGH = 8'((LPDS_LPS_PERIOD * LPDS_DUTY_PCT) / 100);
  localparam int LPDS_SYSCLK_NS = 320;      // sampled link clock period
  localparam int LPDS_CLK_NS = 40;
  // no edge for two link periods means the clock is withdrawn
  localparam logic [7:0] LPDS_IDLE_LIMIT = 8'((2 * LPDS_SYSCLK_NS) / LPDS_CLK_NS);
  localparam logic [31:0] LPDS_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    LPDS_ACTIVE = 2'b00,
    LPDS_STOPPING = 2'b01,
    LPDS_DOWN = 2'b11,
    LPDS_WAKING = 2'b10
  } lpds_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lpds_bus_s;

endpackage : lpds_pkg

// [lpds_top.sv]
`timescale 1ns/1ns
// Overview of operation
// - soft bit or pin requests power-down
// - power-down request stops pulse output
// - clock gone while stopping on request: clear active, init; set inactive
// - inactive flag reads one when down
// - init flag bit 3, forced by legacy
// - pulses 1-2.75 MHz, duty 23-28 percent
module lpds_top
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register port
  input wire lpds_pkg::lpds_bus_s BUS,
  output logic [31:0] RDATA,
  // phy side pins
  input wire logic SYSCLK,
  input wire logic POWER_DOWN_PIN,
  input wire logic LEGACY_PHY_SEL,
  input wire logic PHY_LINK_INIT,
  output logic LPS,
  output logic POWERED_DOWN
);
  import lpds_pkg::*;

  // ==========================================================
  // register port decode

  // one strobe aimed at one register index
  function automatic logic bus_hit(logic strobe, logic [3:0] addr, logic [3:0] index);
    bus_hit = strobe && (addr == index);
  endfunction : bus_hit

  // ==========================================================
  // synchronisers
  logic [2:0] sclk_r;
  logic [2:0] sclk_nxt;
  logic [1:0] pin_r;
  logic [1:0] pin_nxt;
  logic [1:0] leg_r;
  logic [1:0] leg_nxt;
  logic [1:0] init_r;
  logic [1:0] init_nxt;
  logic edge_seen;

  // sample outside levels, third stage for edge finding
  always_comb
  begin
    sclk_nxt = {sclk_r[1:0], SYSCLK};
    pin_nxt = {pin_r[0], POWER_DOWN_PIN};
    leg_nxt = {leg_r[0], LEGACY_PHY_SEL};
    init_nxt = {init_r[0], PHY_LINK_INIT};
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sclk_r <= 3'h0;
      pin_r <= 2'h0;
      leg_r <= 2'h0;
      init_r <= 2'h0;
    end
    else
    begin
      sclk_r <= sclk_nxt;
      pin_r <= pin_nxt;
      leg_r <= leg_nxt;
      init_r <= init_nxt;
    end
  end

  assign edge_seen = sclk_r[1] & ~sclk_r[2];

  // ==========================================================
  // power state and flags
  lpds_state_e state_r;
  lpds_state_e state_nxt;
  logic [7:0] idle_r;
  logic [7:0] idle_nxt;
  logic soft_down_r;
  logic soft_down_nxt;
  logic [7:0] per_r;
  logic [7:0] per_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic clk_act_r;
  logic clk_act_nxt;
  logic clk_inact_r;
  logic clk_inact_nxt;
  logic link_init_r;
  logic link_init_nxt;
  logic pdo_r;
  logic pdo_nxt;
  logic req;
  logic run;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic wr_status;
  logic wr_config;
  logic rd_status;
  logic rd_config;

  // decoded register strobes
  assign wr_status = bus_hit(BUS.wr, BUS.addr, LPDS_PSR_ADDR);
  assign wr_config = bus_hit(BUS.wr, BUS.addr, LPDS_LPSCFG_ADDR);
  assign rd_status = bus_hit(BUS.rd, BUS.addr, LPDS_PSR_ADDR);
  assign rd_config = bus_hit(BUS.rd, BUS.addr, LPDS_LPSCFG_ADDR);

  // power-down request from software or the pin
  assign req = soft_down_r | pin_r[1];
  assign run = ~req;

  // next-state, clock watchdog, software writes and read data
  always_comb
  begin
    state_nxt = state_r;
    soft_down_nxt = soft_down_r;
    per_nxt = per_r;
    hi_nxt = hi_r;
    // cycles since the last link clock rise, held at the limit
    idle_nxt = edge_seen ? 8'h00 : idle_r;
    if (!edge_seen && idle_r != LPDS_IDLE_LIMIT)
    begin
      idle_nxt = idle_r + 8'h01;
    end
    case (state_r)
      LPDS_ACTIVE:
        if (req) state_nxt = LPDS_STOPPING;
      LPDS_STOPPING:
        if (idle_r == LPDS_IDLE_LIMIT) state_nxt = LPDS_DOWN;
        else if (!req) state_nxt = LPDS_ACTIVE;
      LPDS_DOWN:
        if (!req) state_nxt = LPDS_WAKING;
      LPDS_WAKING:
        if (edge_seen) state_nxt = LPDS_ACTIVE;
        else if (req) state_nxt = LPDS_DOWN;
      default:
        state_nxt = LPDS_ACTIVE;
    endcase
    if (wr_status)
    begin
      soft_down_nxt = BUS.wdata[LPDS_SOFT_DOWN_BIT];
    end
    if (wr_config)
    begin
      hi_nxt = BUS.wdata[LPDS_HIGH_MSB:LPDS_HIGH_LSB];
      per_nxt = BUS.wdata[LPDS_PER_MSB:LPDS_PER_LSB];
    end
    // clock-activity flags follow the state
    clk_act_nxt = (state_nxt == LPDS_ACTIVE) || (state_nxt == LPDS_STOPPING);
    clk_inact_nxt = ~clk_act_nxt;
    link_init_nxt = leg_r[1] | (clk_act_nxt & init_r[1]);
    pdo_nxt = clk_inact_nxt;
    rd_nxt = LPDS_ZERO;
    if (rd_status)
    begin
      rd_nxt[LPDS_SOFT_DOWN_BIT] = soft_down_r;
      rd_nxt[LPDS_CLK_ACT_BIT] = clk_act_r;
      rd_nxt[LPDS_CLK_INACT_BIT] = clk_inact_r;
      rd_nxt[LPDS_LINK_INIT_BIT] = link_init_r;
      rd_nxt[LPDS_PDPIN_BIT] = pin_r[1];
      rd_nxt[LPDS_LEGACY_BIT] = leg_r[1];
      rd_nxt[LPDS_REQ_BIT] = req;
    end
    else if (rd_config)
    begin
      rd_nxt[LPDS_PER_MSB:LPDS_HIGH_LSB] = {per_r, hi_r};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= LPDS_ACTIVE;
      idle_r <= 8'h00;
      soft_down_r <= 1'b0;
      per_r <= LPDS_LPS_PERIOD;
      hi_r <= LPDS_LPS_HIGH;
      clk_act_r <= 1'b1;
      clk_inact_r <= 1'b0;
      link_init_r <= 1'b0;
      pdo_r <= 1'b0;
      rd_r <= LPDS_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      idle_r <= idle_nxt;
      soft_down_r <= soft_down_nxt;
      per_r <= per_nxt;
      hi_r <= hi_nxt;
      clk_act_r <= clk_act_nxt;
      clk_inact_r <= clk_inact_nxt;
      link_init_r <= link_init_nxt;
      pdo_r <= pdo_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ==========================================================
  // pulse generator, output registered inside
  lpds_lps_gen u_lps
  (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .run(run),
    .period(per_r),
    .high(hi_r),
    .lps(LPS)
  );

  assign RDATA = rd_r;
  assign POWERED_DOWN = pdo_r;

endmodule : lpds_top

// [lpds_top_asserts.sv]
`timescale 1ns/1ns
module lpds_top_asserts
(
  // clocks
  input logic CORE_CLK,
  input logic RST_N,
  // bus
  input lpds_pkg::lpds_bus_s BUS,
  input logic [31:0] RDATA,
  // phy
  input logic SYSCLK,
  input logic POWER_DOWN_PIN,
  input logic LEGACY_PHY_SEL,
  input logic PHY_LINK_INIT,
  input logic LPS,
  input logic POWERED_DOWN
);
  import lpds_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic sys_r;
  logic [4:0] still_r, still_nxt;
  // cycles since the link clock last moved
  always_comb still_nxt = (SYSCLK != sys_r) ? 5'h00 : still_r + {4'h0, still_r != 5'h1F};
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N) {sys_r, still_r} <= 6'h00;
    else {sys_r, still_r} <= {SYSCLK, still_nxt};
  sequence soft_wr(logic v);
    BUS.wr && BUS.addr == LPDS_PSR_ADDR && BUS.wdata[0] == v;
  endsequence
  sequence psr_rd;
    BUS.rd && BUS.addr == LPDS_PSR_ADDR;
  endsequence
  // ==========================================
  // power-down, pulse and flag checks
  a_soft_stop: assert property (soft_wr(1'b1) |-> ##2 !LPS[*2])
    else $error("pulse after soft power-down");
  a_pin_stop: assert property (POWER_DOWN_PIN[*5] |-> !LPS)
    else $error("pulse while pin held");
  a_low_phase: assert property ($fell(LPS) |-> !LPS[*8])
    else $error("pulse low phase short");
  a_still_down: assert property (still_r == 5'h18 |-> POWERED_DOWN)
    else $error("not down without clock");
  a_rise_wakes: assert property ($rose(SYSCLK) |-> ##[1:8] !POWERED_DOWN)
    else $error("still down with clock");
  a_legacy_init: assert property (LEGACY_PHY_SEL[*5] ##0 psr_rd |=> RDATA[3])
    else $error("init flag low with legacy");
  a_release_run: assert property (!POWER_DOWN_PIN[*4] ##0 soft_wr(1'b0) |-> ##[1:20] LPS)
    else $error("no pulse after release");
endmodule : lpds_top_asserts
bind lpds_top lpds_top_asserts u_lpds_top_asserts (.CORE_CLK, .RST_N, .BUS, .RDATA, .SYSCLK,
  .POWER_DOWN_PIN, .LEGACY_PHY_SEL, .PHY_LINK_INIT, .LPS, .POWERED_DOWN);

// [lpds_top_tb.sv]
`timescale 1ns/1ns
module lpds_top_tb;
  import lpds_pkg::*;
  logic clk = 0, rst_n = 0, pin = 0, legacy = 0, sysclk, init, lps, down;
  lpds_bus_s bus = '0;
  logic [31:0] rdata;
  int err_total = 0, samples_checked = 0, h, p;
  // ==========================================
  // clock and design
  always #20 clk = ~clk;
  lpds_top u_lpds_top (.CORE_CLK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
    .SYSCLK(sysclk), .POWER_DOWN_PIN(pin), .LEGACY_PHY_SEL(legacy),
    .PHY_LINK_INIT(init), .LPS(lps), .POWERED_DOWN(down));
  lpds_phy_model u_lpds_phy_model (.lps(lps), .sysclk(sysclk), .link_init(init));
  task automatic chk(logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic acc(logic [3:0] a, logic [31:0] d, logic w);
    @(posedge clk);
    bus <= '{a, d, w, !w};
    @(posedge clk);
    bus <= '0;
  endtask : acc
  task automatic rd(logic [3:0] a, logic [31:0] m, e);
    acc(a, 0, 0);
    #1 chk(rdata & m, e);
  endtask : rd
  task automatic wait_down(logic v);
    for (int i = 0; i < 300 && down !== v; i++) @(negedge clk);
    chk(down, v);
  endtask : wait_down
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // watchdog
  initial
  begin
    #100000 err_total++;
    complete_run;
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (20) @(negedge clk);
    rd(LPDS_LPSCFG_ADDR, 32'hFFFF, 32'h0D03);
    rd(4'h7, 32'hFFFFFFFF, 32'h0);
    {h, p} = 0;
    // start from a low phase so a whole pulse is measured
    while (lps !== 0) @(negedge clk);
    while (lps !== 1) @(negedge clk);
    while (lps === 1) @(negedge clk) h++;
    while (lps !== 1) @(negedge clk) p++;
    p += h;
    chk(h * 100 >= 23 * p && h * 100 <= 28 * p, 1);
    chk(p * 40 >= 364 && p * 40 <= 1000, 1);
    rd(LPDS_PSR_ADDR, 32'h4F, 32'h0A);
    acc(LPDS_PSR_ADDR, 1, 1);
    wait_down(1);
    chk(lps, 0);
    rd(LPDS_PSR_ADDR, 32'h4F, 32'h45);
    @(posedge clk) legacy <= 1;
    repeat (6) @(posedge clk);
    // legacy forces the init flag, so power state is judged from the inactive flag
    rd(LPDS_PSR_ADDR, 32'h0E, 32'h0C);
    @(posedge clk) legacy <= 0;
    acc(LPDS_PSR_ADDR, 0, 1);
    wait_down(0);
    rd(LPDS_PSR_ADDR, 32'h4F, 32'h0A);
    @(posedge clk) pin <= 1;
    wait_down(1);
    rd(LPDS_PSR_ADDR, 32'h5F, 32'h54);
    @(posedge clk) pin <= 0;
    wait_down(0);
    complete_run;
  end
endmodule : lpds_top_tb
